// ==== hw/pbgc_general_control.v ====
// General control register of the bridge with its decoded control outputs
// Functional notes
// - Retry field picks 25us, 1ms, 25ms, 50ms retry window before retry status
// - Bits 29:28 always read as zero
// - Low-power bit selects half-amplitude no-preemphasis transmit; resets to 0
// - Revision bit: 0 reports 010b and no-soft-reset 0; 1 reports 011b and 1
// - Strict bit with zero low-priority count gives extended VC priority over VC0
// - Strict bit sets low-priority count default: 0 gives 001b, 1 gives 000b
// - Force bit makes every upstream memory read a prefetchable read multiple
// - Default bit sets link power field power-up value: 00b or 11b
// - Policy 000 ignores short slot power; 001 asserts the shortfall pin
// - Policy 010 stops masked secondary clocks; 011 also asserts the pin
// - Policy 100 answers unsupported request except config and slot power messages
// - Link reset, global reset or power-on reset restore all defaults
// - Register sits at offset d4h and resets to 8206c000h
`include "pbgc_defs.vh"
module pbgc_general_control #(
	parameter RETRY_CYC_0 = `PBGC_RETRY_CYC_0,
	parameter RETRY_CYC_1 = `PBGC_RETRY_CYC_1,
	parameter RETRY_CYC_2 = `PBGC_RETRY_CYC_2,
	parameter RETRY_CYC_3 = `PBGC_RETRY_CYC_3
) (
	input wire CLOCK,
	input wire RST,
	input wire LINK_RESET_PIN_N,
	input wire GLOBAL_RESET_PIN_N,
	input wire CFG_WR,
	input wire CFG_RD,
	input wire [7:0] CFG_ADDR,
	input wire [3:0] CFG_BE,
	input wire [31:0] CFG_WDATA,
	output reg [31:0] CFG_RDATA,
	output reg CFG_RVALID,
	input wire SLOT_POWER_SHORT,
	input wire [2:0] LOW_PRIORITY_COUNT,
	input wire REQ_IS_CFG_OR_SPL,
	input wire RETRY_START,
	output wire RETRY_EXPIRED,
	output wire TX_LOW_POWER,
	output wire [2:0] PM_REVISION_FIELD,
	output wire NO_SOFT_RESET,
	output wire EXT_VC_PRIORITY,
	output wire [2:0] LOW_PRIORITY_DEFAULT,
	output wire FORCE_PREFETCH_READS,
	output wire [1:0] LINK_PM_CONTROL_DEFAULT,
	output wire POWER_SHORTFALL_PIN,
	output wire SEC_CLOCK_STOP,
	output wire UNSUPPORTED_REQUEST
);
	// ----------------------------------------
	// Reset pin synchronisers
	// ----------------------------------------
	// Pins are asynchronous; only the second stage feeds logic
	reg [1:0] lrst_sync1_ff;
	reg [1:0] lrst_sync2_ff;
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			lrst_sync1_ff <= 2'h3;
			lrst_sync2_ff <= 2'h3;
		end else begin
			lrst_sync1_ff <= {LINK_RESET_PIN_N, GLOBAL_RESET_PIN_N};
			lrst_sync2_ff <= lrst_sync1_ff;
		end
	end
	wire soft_reset = ~lrst_sync2_ff[1] | ~lrst_sync2_ff[0];

	// ----------------------------------------
	// Register
	// ----------------------------------------
	function [31:0] pbgc_be_mask;
		input [3:0] be;
		begin
			pbgc_be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		end
	endfunction

	reg [31:0] ctrl_ff;
	reg [31:0] nxt_ctrl;
	wire hit = (CFG_ADDR == `PBGC_GEN_CTRL_OFFSET);
	wire [31:0] wmask = pbgc_be_mask(CFG_BE) & `PBGC_WRITE_MASK;
	always @* begin
		nxt_ctrl = ctrl_ff;
		if (soft_reset) begin
			nxt_ctrl = `PBGC_GEN_CTRL_RESET;
		end else if (CFG_WR && hit) begin
			nxt_ctrl = (ctrl_ff & ~wmask) | (CFG_WDATA & wmask);
		end
	end
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			ctrl_ff <= `PBGC_GEN_CTRL_RESET;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// Unmapped offsets read as zero
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			CFG_RDATA <= 32'h00000000;
			CFG_RVALID <= 1'b0;
		end else begin
			CFG_RVALID <= CFG_RD;
			CFG_RDATA <= (CFG_RD && hit) ? (ctrl_ff & `PBGC_WRITE_MASK) : 32'h00000000;
		end
	end

	// ----------------------------------------
	// Decoded controls
	// ----------------------------------------
	// Data outputs load from the next register value, so they change on the
	// same edge as the register and never lag a write
	reg tx_low_power_ff;
	reg [2:0] pm_rev_field_ff;
	reg no_soft_reset_ff;
	reg [2:0] low_pri_default_ff;
	reg force_prefetch_ff;
	reg [1:0] link_pm_default_ff;
	wire nxt_pm_rev = nxt_ctrl[`PBGC_PM_REV_BIT];
	wire nxt_strict = nxt_ctrl[`PBGC_STRICT_PRIO_BIT];
	wire nxt_link_pm = nxt_ctrl[`PBGC_LINK_PM_DEF_BIT];
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			tx_low_power_ff <= 1'b0;
			pm_rev_field_ff <= `PBGC_PM_REV_V11;
			no_soft_reset_ff <= 1'b0;
			low_pri_default_ff <= `PBGC_LOWPRI_STRICT;
			force_prefetch_ff <= 1'b0;
			link_pm_default_ff <= `PBGC_LINK_PM_OFF;
		end else begin
			tx_low_power_ff <= nxt_ctrl[`PBGC_LOW_POWER_BIT];
			pm_rev_field_ff <= nxt_pm_rev ? `PBGC_PM_REV_V12 : `PBGC_PM_REV_V11;
			no_soft_reset_ff <= nxt_pm_rev;
			low_pri_default_ff <= nxt_strict ? `PBGC_LOWPRI_STRICT : `PBGC_LOWPRI_DEFAULT;
			force_prefetch_ff <= nxt_ctrl[`PBGC_FORCE_PREFETCH_BIT];
			link_pm_default_ff <= nxt_link_pm ? `PBGC_LINK_PM_ON : `PBGC_LINK_PM_OFF;
		end
	end
	assign TX_LOW_POWER = tx_low_power_ff;
	assign PM_REVISION_FIELD = pm_rev_field_ff;
	assign NO_SOFT_RESET = no_soft_reset_ff;
	assign LOW_PRIORITY_DEFAULT = low_pri_default_ff;
	assign FORCE_PREFETCH_READS = force_prefetch_ff;
	assign LINK_PM_CONTROL_DEFAULT = link_pm_default_ff;
	// The arbiter samples its count every cycle, so this stays combinational
	assign EXT_VC_PRIORITY = ctrl_ff[`PBGC_STRICT_PRIO_BIT] &&
		(LOW_PRIORITY_COUNT == `PBGC_LOWPRI_STRICT);

	// Shortage input is asynchronous to this clock
	reg short_sync1_ff;
	reg short_sync2_ff;
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			short_sync1_ff <= 1'b0;
			short_sync2_ff <= 1'b0;
		end else begin
			short_sync1_ff <= SLOT_POWER_SHORT;
			short_sync2_ff <= short_sync1_ff;
		end
	end
	// Policy decode as {unsupported request, clock stop, pin}; reserved codes
	// behave like ignore, so a stray write cannot cut power
	function [2:0] pbgc_policy_dec;
		input [2:0] code;
		begin
			case (code)
				`PBGC_POLICY_PIN: pbgc_policy_dec = 3'h1;
				`PBGC_POLICY_CLKSTOP: pbgc_policy_dec = 3'h2;
				`PBGC_POLICY_CLKSTOP_PIN: pbgc_policy_dec = 3'h3;
				`PBGC_POLICY_UR: pbgc_policy_dec = 3'h4;
				default: pbgc_policy_dec = 3'h0;
			endcase
		end
	endfunction
	wire [2:0] nxt_policy_act = pbgc_policy_dec(nxt_ctrl[`PBGC_POLICY_HI:`PBGC_POLICY_LO]);
	// Policy actions leave flip-flops so a policy write cannot glitch the pins;
	// the cost is one more cycle of latency from the shortage input
	reg shortfall_pin_ff;
	reg clock_stop_ff;
	reg ur_armed_ff;
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			shortfall_pin_ff <= 1'b0;
			clock_stop_ff <= 1'b0;
			ur_armed_ff <= 1'b0;
		end else begin
			shortfall_pin_ff <= short_sync2_ff && nxt_policy_act[0];
			clock_stop_ff <= short_sync2_ff && nxt_policy_act[1];
			ur_armed_ff <= short_sync2_ff && nxt_policy_act[2];
		end
	end
	assign POWER_SHORTFALL_PIN = shortfall_pin_ff;
	assign SEC_CLOCK_STOP = clock_stop_ff;
	// Follows the current request, so the exemption stays combinational
	assign UNSUPPORTED_REQUEST = ur_armed_ff && !REQ_IS_CFG_OR_SPL;

	// ----------------------------------------
	// Configuration retry timer
	// ----------------------------------------
	reg [22:0] retry_cnt_ff;
	reg retry_run_ff;
	reg [22:0] retry_limit;
	always @* begin
		case (ctrl_ff[`PBGC_RETRY_HI:`PBGC_RETRY_LO])
			2'h0: retry_limit = RETRY_CYC_0[22:0];
			2'h1: retry_limit = RETRY_CYC_1[22:0];
			2'h2: retry_limit = RETRY_CYC_2[22:0];
			default: retry_limit = RETRY_CYC_3[22:0];
		endcase
	end
	always @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			retry_cnt_ff <= 23'h000000;
			retry_run_ff <= 1'b0;
		end else if (RETRY_START || soft_reset) begin
			retry_cnt_ff <= 23'h000000;
			retry_run_ff <= RETRY_START && !soft_reset;
		end else if (retry_run_ff) begin
			if (retry_cnt_ff >= retry_limit - 23'h000001) begin
				retry_run_ff <= 1'b0;
			end
			retry_cnt_ff <= retry_cnt_ff + 23'h000001;
		end
	end
	assign RETRY_EXPIRED = retry_run_ff && (retry_cnt_ff >= retry_limit - 23'h000001);
endmodule

// ==== hw/pbgc_defs.vh ====
// Offsets, field positions, reset values and timing counts of the general control register
`ifndef PBGC_DEFS_VH
`define PBGC_DEFS_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define PBGC_GEN_CTRL_OFFSET 8'hd4
`define PBGC_GEN_CTRL_RESET 32'h8206c000
// Bits that software may change; 29:28 read as zero
`define PBGC_WRITE_MASK 32'hcfffffff
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PBGC_RETRY_HI 31
`define PBGC_RETRY_LO 30
`define PBGC_LOW_POWER_BIT 27
`define PBGC_PM_REV_BIT 26
`define PBGC_STRICT_PRIO_BIT 25
`define PBGC_FORCE_PREFETCH_BIT 24
`define PBGC_LINK_PM_DEF_BIT 23
`define PBGC_POLICY_HI 22
`define PBGC_POLICY_LO 20
// ----------------------------------------
// Encodings
// ----------------------------------------
`define PBGC_POLICY_IGNORE 3'h0
`define PBGC_POLICY_PIN 3'h1
`define PBGC_POLICY_CLKSTOP 3'h2
`define PBGC_POLICY_CLKSTOP_PIN 3'h3
`define PBGC_POLICY_UR 3'h4
`define PBGC_PM_REV_V11 3'h2
`define PBGC_PM_REV_V12 3'h3
`define PBGC_LOWPRI_STRICT 3'h0
`define PBGC_LOWPRI_DEFAULT 3'h1
`define PBGC_LINK_PM_OFF 2'h0
`define PBGC_LINK_PM_ON 2'h3
// ----------------------------------------
// Retry times in microseconds and cycles at 100 MHz
// ----------------------------------------
`define PBGC_CLK_MHZ 100
`define PBGC_RETRY_US_0 25
`define PBGC_RETRY_US_1 1000
`define PBGC_RETRY_US_2 25000
`define PBGC_RETRY_US_3 50000
`define PBGC_RETRY_CYC_0 (`PBGC_RETRY_US_0 * `PBGC_CLK_MHZ)
`define PBGC_RETRY_CYC_1 (`PBGC_RETRY_US_1 * `PBGC_CLK_MHZ)
`define PBGC_RETRY_CYC_2 (`PBGC_RETRY_US_2 * `PBGC_CLK_MHZ)
`define PBGC_RETRY_CYC_3 (`PBGC_RETRY_US_3 * `PBGC_CLK_MHZ)
`endif

// ==== verif/pbgc_checker.sv ====
// Port assertions for the general control register
module pbgc_checker (
	input wire CLOCK,
	input wire RST,
	input wire CFG_WR,
	input wire CFG_RD,
	input wire CFG_RVALID,
	input wire NO_SOFT_RESET,
	input wire TX_LOW_POWER,
	input wire EXT_VC_PRIORITY,
	input wire REQ_IS_CFG_OR_SPL,
	input wire POWER_SHORTFALL_PIN,
	input wire SEC_CLOCK_STOP,
	input wire UNSUPPORTED_REQUEST,
	input wire [7:0] CFG_ADDR,
	input wire [31:0] CFG_RDATA,
	input wire [2:0] PM_REVISION_FIELD,
	input wire [2:0] LOW_PRIORITY_COUNT,
	input wire [2:0] LOW_PRIORITY_DEFAULT,
	input wire [1:0] LINK_PM_CONTROL_DEFAULT
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	a_read_answer: assert property (CFG_RD |=> CFG_RVALID) else $error("no answer");
	a_answer_cause: assert property (CFG_RVALID |-> $past(CFG_RD)) else $error("stray answer");
	a_reserved_zero: assert property (CFG_RVALID |-> CFG_RDATA[29:28] == 2'h0) else $error("rsv");
	a_unmapped_zero: assert property (CFG_RD && CFG_ADDR != 8'hd4 |=> CFG_RDATA == 32'h0)
		else $error("unmapped data");
	a_readback_match: assert property (CFG_RD && !CFG_WR && CFG_ADDR == 8'hd4 |=>
		CFG_RDATA[27:26] == {TX_LOW_POWER, NO_SOFT_RESET}) else $error("readback");
	a_revision_pair: assert property (PM_REVISION_FIELD == {2'h1, NO_SOFT_RESET})
		else $error("revision");
	a_ext_priority: assert property (EXT_VC_PRIORITY ==
		(LOW_PRIORITY_DEFAULT == 3'h0 && LOW_PRIORITY_COUNT == 3'h0)) else $error("vc");
	a_link_pm_pair: assert property (LINK_PM_CONTROL_DEFAULT[1] == LINK_PM_CONTROL_DEFAULT[0])
		else $error("link pm");
	a_ur_exempt: assert property (REQ_IS_CFG_OR_SPL |-> !UNSUPPORTED_REQUEST) else $error("ur");
	a_policy_exclusive: assert property (UNSUPPORTED_REQUEST |->
		!POWER_SHORTFALL_PIN && !SEC_CLOCK_STOP) else $error("policy");
	c_read: cover property (CFG_RVALID);
	c_ur: cover property (UNSUPPORTED_REQUEST);
	c_both: cover property (POWER_SHORTFALL_PIN && SEC_CLOCK_STOP);
endmodule
bind pbgc_general_control pbgc_checker chk (
	.CLOCK(CLOCK), .RST(RST), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_RVALID(CFG_RVALID),
	.NO_SOFT_RESET(NO_SOFT_RESET), .TX_LOW_POWER(TX_LOW_POWER),
	.EXT_VC_PRIORITY(EXT_VC_PRIORITY), .REQ_IS_CFG_OR_SPL(REQ_IS_CFG_OR_SPL),
	.POWER_SHORTFALL_PIN(POWER_SHORTFALL_PIN), .SEC_CLOCK_STOP(SEC_CLOCK_STOP),
	.UNSUPPORTED_REQUEST(UNSUPPORTED_REQUEST), .CFG_ADDR(CFG_ADDR), .CFG_RDATA(CFG_RDATA),
	.PM_REVISION_FIELD(PM_REVISION_FIELD), .LOW_PRIORITY_COUNT(LOW_PRIORITY_COUNT),
	.LOW_PRIORITY_DEFAULT(LOW_PRIORITY_DEFAULT),
	.LINK_PM_CONTROL_DEFAULT(LINK_PM_CONTROL_DEFAULT));

// ==== verif/pbgc_far_side.sv ====
// Upstream port model: VC arbitration count and request kind
module pbgc_far_side (
	input wire clock,
	output logic [2:0] low_prio_count,
	output logic req_exempt
);
	timeunit 1ns;
	timeprecision 1ps;
	integer seed = 94777;
	// Late update so the bench sees settled values at the falling edge
	always @(negedge clock) begin
		low_prio_count <= 3'($random(seed)) & 3'h5;
		req_exempt <= 1'($random(seed));
	end
endmodule

// ==== verif/test_pcie_bridge_general_control.sv ====
// Self-checking bench for the general control register
module test_pcie_bridge_general_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLOCK = 0, RST = 1, LINK_RESET_PIN_N = 1, GLOBAL_RESET_PIN_N = 1, CFG_WR = 0;
	logic CFG_RD = 0, SLOT_POWER_SHORT = 0, RETRY_START = 0, REQ_IS_CFG_OR_SPL;
	logic [7:0] CFG_ADDR = 8'hd4;
	logic [3:0] CFG_BE = 4'hf;
	logic [31:0] CFG_WDATA = 32'h0, CFG_RDATA, d, r, m;
	logic [2:0] LOW_PRIORITY_COUNT, PM_REVISION_FIELD, LOW_PRIORITY_DEFAULT;
	logic [1:0] LINK_PM_CONTROL_DEFAULT;
	logic CFG_RVALID, RETRY_EXPIRED, TX_LOW_POWER, NO_SOFT_RESET, EXT_VC_PRIORITY;
	logic FORCE_PREFETCH_READS, POWER_SHORTFALL_PIN, SEC_CLOCK_STOP, UNSUPPORTED_REQUEST;
	integer seed = 94777, bad_count = 0, checks = 0, i, n;
	always #5 CLOCK = ~CLOCK;
	// Short retry counts keep the run brief
	pbgc_general_control #(.RETRY_CYC_0(4), .RETRY_CYC_1(6), .RETRY_CYC_2(8),
		.RETRY_CYC_3(10)) DUT (
		.CLOCK(CLOCK), .RST(RST), .LINK_RESET_PIN_N(LINK_RESET_PIN_N),
		.GLOBAL_RESET_PIN_N(GLOBAL_RESET_PIN_N), .CFG_WR(CFG_WR), .CFG_RD(CFG_RD),
		.CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
		.CFG_RVALID(CFG_RVALID), .SLOT_POWER_SHORT(SLOT_POWER_SHORT),
		.LOW_PRIORITY_COUNT(LOW_PRIORITY_COUNT), .REQ_IS_CFG_OR_SPL(REQ_IS_CFG_OR_SPL),
		.RETRY_START(RETRY_START), .RETRY_EXPIRED(RETRY_EXPIRED), .TX_LOW_POWER(TX_LOW_POWER),
		.PM_REVISION_FIELD(PM_REVISION_FIELD), .NO_SOFT_RESET(NO_SOFT_RESET),
		.EXT_VC_PRIORITY(EXT_VC_PRIORITY), .LOW_PRIORITY_DEFAULT(LOW_PRIORITY_DEFAULT),
		.FORCE_PREFETCH_READS(FORCE_PREFETCH_READS),
		.LINK_PM_CONTROL_DEFAULT(LINK_PM_CONTROL_DEFAULT),
		.POWER_SHORTFALL_PIN(POWER_SHORTFALL_PIN), .SEC_CLOCK_STOP(SEC_CLOCK_STOP),
		.UNSUPPORTED_REQUEST(UNSUPPORTED_REQUEST));
	pbgc_far_side far (.clock(CLOCK), .low_prio_count(LOW_PRIORITY_COUNT),
		.req_exempt(REQ_IS_CFG_OR_SPL));
	task chk(input string s, input [31:0] e, input [31:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s exp %h got %h", s, e, g);
		end
	endtask
	task wr(input [31:0] v, input [3:0] b);
		@(negedge CLOCK);
		{CFG_WR, CFG_ADDR, CFG_WDATA, CFG_BE} = {1'b1, 8'hd4, v, b};
		@(negedge CLOCK);
		CFG_WR = 0;
		m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & 32'hcfffffff;
		r = r & ~m | v & m;
	endtask
	task rd(input [7:0] a, input [31:0] e);
		@(negedge CLOCK);
		{CFG_RD, CFG_ADDR} = {1'b1, a};
		@(negedge CLOCK);
		CFG_RD = 0;
		chk("rdata", e, CFG_RDATA);
	endtask
	function [14:0] dec(input [31:0] v, input [2:0] c, input s, input q);
		dec = {v[27], 2'h1, v[26], v[26], 2'h0, ~v[25], v[24], {2{v[23]}}, v[25] && c == 3'h0,
			s && (v[22:20] == 3'h1 || v[22:20] == 3'h3), s && v[22:21] == 2'h1,
			s && v[22:20] == 3'h4 && !q};
	endfunction
	task wrap_up;
		$display("checks %0d errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		wrap_up;
	end
	initial begin
		repeat (6) @(negedge CLOCK);
		RST = 0;
		r = 32'h8206c000;
		rd(8'hd4, r);
		rd(8'hd8, 32'h0);
		for (i = 0; i < 30; i++) begin
			d = $random(seed);
			if (i < 5) d[22:20] = i;
			else d[21:20] = d[21:20] & ~{2{d[22]}};
			if (i == 5) d = 32'hffcfffff;
			SLOT_POWER_SHORT = i < 5 || ($random(seed) & 1);
			wr(d, i < 6 ? 4'hf : $random(seed));
			rd(8'hd4, r);
			chk("decode",
				dec(r, LOW_PRIORITY_COUNT, SLOT_POWER_SHORT, REQ_IS_CFG_OR_SPL),
				{TX_LOW_POWER, PM_REVISION_FIELD, NO_SOFT_RESET, LOW_PRIORITY_DEFAULT,
				FORCE_PREFETCH_READS, LINK_PM_CONTROL_DEFAULT, EXT_VC_PRIORITY,
				POWER_SHORTFALL_PIN, SEC_CLOCK_STOP, UNSUPPORTED_REQUEST});
		end
		for (i = 0; i < 4; i++) begin
			wr({i[1:0], 30'h0}, 4'h8);
			RETRY_START = 1;
			@(negedge CLOCK);
			RETRY_START = 0;
			for (n = 1; RETRY_EXPIRED !== 1'b1 && n < 40; n++) @(negedge CLOCK);
			chk("retry", 4 + 2 * i, n);
		end
		for (i = 0; i < 2; i++) begin
			wr(32'h0, 4'hf);
			{LINK_RESET_PIN_N, GLOBAL_RESET_PIN_N} = i ? 2'b10 : 2'b01;
			repeat (4) @(negedge CLOCK);
			{LINK_RESET_PIN_N, GLOBAL_RESET_PIN_N} = 2'b11;
			repeat (3) @(negedge CLOCK);
			r = 32'h8206c000;
			rd(8'hd4, r);
		end
		wrap_up;
	end
endmodule
